/* File: src/logic_cell_defines.vh */
// Purpose: constants for the configurable logic cell block
// Assumes: apb register bus, 32-bit data, word-aligned registers
// Notes: How it works list below
// How it works
// - control bit 6 reads the present level of the cell output
// - control bit 5 set inverts the function result on the cell output
// - mode codes 000 to 011 pick and-or, or-xor, four-input and, sr latch
// - mode codes 100 to 111 pick the flip-flop and latch elements
// - four 3-bit input selectors in select bits 2:0, 6:4, 10:8, 14:12
// - cell 1 selector 4 routes pin, sibling, capture, serial, comparator, clock, compare
// - cells 2 to 4 use the same pattern; cell 4 code 011 reserved
`ifndef LOGIC_CELL_DEFINES_VH
`define LOGIC_CELL_DEFINES_VH
`define OFS_CONTROL      12'h000
`define OFS_SELECT       12'h004
`define OFS_IRQ_STATUS   12'h008
`define OFS_IRQ_MASK     12'h00c
`define CTL_MODE_LSB     0
`define CTL_OUT_INVERT   5
`define CTL_OUT_LEVEL    6
`define CTL_RISE_IRQ_EN  8
`define CTL_FALL_IRQ_EN  9
`define CTL_RESET        32'h00000000
`define SEL_RESET        32'h00000000
`define IRQ_RISE_BIT     0
`define IRQ_FALL_BIT     1
`define MODE_AND_OR      3'h0
`define MODE_OR_XOR      3'h1
`define MODE_AND4        3'h2
`define MODE_SR_LATCH    3'h3
`define MODE_DFF1_SR     3'h4
`define MODE_DFF2_R      3'h5
`define MODE_JK_R        3'h6
`define MODE_LATCH_SR    3'h7
`endif

/* File: src/input_sync.v */
// Purpose: two flip-flop synchroniser for one selected cell input
// Assumes: input may come from any domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module input_sync (
  input  wire clock,
  input  wire reset,
  input  wire data_in,
  output wire data_out
);
  reg stage1_reg;
  reg stage2_reg;
  always @(posedge clock) begin
    if (reset) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= data_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign data_out = stage2_reg;
endmodule
`default_nettype wire

/* File: src/logic_cell.v */
// Purpose: one configurable logic cell with apb registers and interrupt
// Assumes: single clock, synchronous active-high reset
// Notes: cell_index 3 makes selector-4 code 011 read low
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_defines.vh"
module logic_cell #(
  parameter [1:0] cell_index = 2'd0
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  src_1,
  input  wire [7:0]  src_2,
  input  wire [7:0]  src_3,
  input  wire        cell_pin_b_input,
  input  wire        sibling_cell_out,
  input  wire        capture_output,
  input  wire        serial_data_in,
  input  wire        comparator_three,
  input  wire        clock_calendar_event,
  input  wire        compare_match_event_a,
  input  wire        compare_match_event_b,
  output reg         cell_out,
  output reg         irq
);
  reg  [31:0] control_reg;
  reg  [31:0] control_next;
  reg  [14:0] select_reg;
  reg  [14:0] select_next;
  reg  [1:0]  status_reg;
  reg  [1:0]  status_next;
  reg  [1:0]  mask_reg;
  reg  [1:0]  mask_next;
  reg         core_reg;
  reg         core_next;
  reg         out_prev_reg;
  reg  [31:0] rdata_next;
  reg         hit;
  reg  [7:0]  src_4;
  reg         and_or_next;
  reg         or_xor_next;
  reg         and4_next;
  reg         sr_latch_next;
  reg         dff1_next;
  reg         dff2_next;
  reg         jk_next;
  reg         latch_next;
  wire [2:0]  mode;
  wire [3:0]  raw;
  wire [3:0]  d;
  wire        out_next;
  wire        access;
  wire        wr;
  wire        rd;
  wire        sel_control;
  wire        sel_select;
  wire        sel_status;
  wire        sel_mask;
  wire        rise;
  wire        fall;
  wire [1:0]  events;
  wire        irq_next;

  // an access is taken once, in the cycle before pready rises
  assign access      = psel & penable & ~pready;
  assign wr          = access & pwrite;
  assign rd          = access & ~pwrite;
  assign sel_control = (paddr == `OFS_CONTROL);
  assign sel_select  = (paddr == `OFS_SELECT);
  assign sel_status  = (paddr == `OFS_IRQ_STATUS);
  assign sel_mask    = (paddr == `OFS_IRQ_MASK);
  assign mode        = control_reg[`CTL_MODE_LSB+2:`CTL_MODE_LSB];

  // selector-4 sources; cell 4 code 011 is reserved and reads low
  always @* begin
    src_4[0] = cell_pin_b_input;
    src_4[1] = sibling_cell_out;
    src_4[2] = capture_output;
    src_4[3] = serial_data_in;
    src_4[4] = comparator_three;
    src_4[5] = clock_calendar_event;
    src_4[6] = compare_match_event_a;
    src_4[7] = compare_match_event_b;
    if (cell_index == 2'd3) begin
      src_4[3] = 1'b0;
    end
  end

  assign raw[0] = src_1[select_reg[2:0]];
  assign raw[1] = src_2[select_reg[6:4]];
  assign raw[2] = src_3[select_reg[10:8]];
  assign raw[3] = src_4[select_reg[14:12]];

  // mux outputs may glitch on a selector change; two flops clean them up
  input_sync u_sync_1 (
    .clock    (clock),
    .reset    (reset),
    .data_in  (raw[0]),
    .data_out (d[0])
  );

  input_sync u_sync_2 (
    .clock    (clock),
    .reset    (reset),
    .data_in  (raw[1]),
    .data_out (d[1])
  );

  input_sync u_sync_3 (
    .clock    (clock),
    .reset    (reset),
    .data_in  (raw[2]),
    .data_out (d[2])
  );

  input_sync u_sync_4 (
    .clock    (clock),
    .reset    (reset),
    .data_in  (raw[3]),
    .data_out (d[3])
  );

  // combinational functions
  always @* begin
    and_or_next = (d[0] & d[1]) | (d[2] & d[3]);
    or_xor_next = (d[0] | d[1]) ^ (d[2] | d[3]);
    and4_next   = d[0] & d[1] & d[2] & d[3];
  end

  // sr latch: set from inputs 1/2, reset from inputs 3/4, set wins
  always @* begin
    sr_latch_next = core_reg;
    if (d[0] | d[1]) begin
      sr_latch_next = 1'b1;
    end else if (d[2] | d[3]) begin
      sr_latch_next = 1'b0;
    end
  end

  // one-input d flip-flop: data input 2, set input 4, reset input 3
  always @* begin
    if (d[3]) begin
      dff1_next = 1'b1;
    end else if (d[2]) begin
      dff1_next = 1'b0;
    end else begin
      dff1_next = d[1];
    end
  end

  // two-input d flip-flop: data is input 2 and input 4, reset input 3
  always @* begin
    if (d[2]) begin
      dff2_next = 1'b0;
    end else begin
      dff2_next = d[1] & d[3];
    end
  end

  // jk flip-flop: j input 2, k input 4, reset input 3
  always @* begin
    jk_next = core_reg;
    if (d[2]) begin
      jk_next = 1'b0;
    end else begin
      case ({d[1], d[3]})
        2'b10:   jk_next = 1'b1;
        2'b01:   jk_next = 1'b0;
        2'b11:   jk_next = ~core_reg;
        default: jk_next = core_reg;
      endcase
    end
  end

  // transparent latch: enable input 1, data input 2, set 4, reset 3
  always @* begin
    latch_next = core_reg;
    if (d[3]) begin
      latch_next = 1'b1;
    end else if (d[2]) begin
      latch_next = 1'b0;
    end else if (d[0]) begin
      latch_next = d[1];
    end
  end

  // mode select; sequential elements keep their state in core_reg
  always @* begin
    case (mode)
      `MODE_AND_OR:   core_next = and_or_next;
      `MODE_OR_XOR:   core_next = or_xor_next;
      `MODE_AND4:     core_next = and4_next;
      `MODE_SR_LATCH: core_next = sr_latch_next;
      `MODE_DFF1_SR:  core_next = dff1_next;
      `MODE_DFF2_R:   core_next = dff2_next;
      `MODE_JK_R:     core_next = jk_next;
      `MODE_LATCH_SR: core_next = latch_next;
      default:        core_next = core_reg;
    endcase
  end

  assign out_next = core_next ^ control_reg[`CTL_OUT_INVERT];

  always @(posedge clock) begin
    if (reset) begin
      core_reg <= 1'b0;
      cell_out <= 1'b0;
    end else begin
      core_reg <= core_next;
      cell_out <= out_next;
    end
  end

  // edge detection on the cell output
  assign rise   = cell_out & ~out_prev_reg;
  assign fall   = ~cell_out & out_prev_reg;
  assign events = {fall & control_reg[`CTL_FALL_IRQ_EN],
                   rise & control_reg[`CTL_RISE_IRQ_EN]};

  always @(posedge clock) begin
    if (reset) begin
      out_prev_reg <= 1'b0;
    end else begin
      out_prev_reg <= cell_out;
    end
  end

  // the level bit is not stored; a read shows the live output
  always @* begin
    control_next = control_reg;
    if (wr && sel_control) begin
      control_next = 32'h00000000;
      control_next[`CTL_MODE_LSB+2:`CTL_MODE_LSB] = pwdata[`CTL_MODE_LSB+2:`CTL_MODE_LSB];
      control_next[`CTL_OUT_INVERT]  = pwdata[`CTL_OUT_INVERT];
      control_next[`CTL_RISE_IRQ_EN] = pwdata[`CTL_RISE_IRQ_EN];
      control_next[`CTL_FALL_IRQ_EN] = pwdata[`CTL_FALL_IRQ_EN];
    end
  end

  always @* begin
    select_next = select_reg;
    if (wr && sel_select) begin
      select_next = pwdata[14:0] & 15'h7777;
    end
  end

  always @* begin
    mask_next = mask_reg;
    if (wr && sel_mask) begin
      mask_next = pwdata[1:0];
    end
  end

  // read clears, a new event in the same cycle wins
  always @* begin
    if (rd && sel_status) begin
      status_next = events;
    end else begin
      status_next = status_reg | events;
    end
  end

  assign irq_next = |(status_next & mask_next);

  always @(posedge clock) begin
    if (reset) begin
      control_reg <= `CTL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      select_reg <= 15'h0000;
    end else begin
      select_reg <= select_next;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      mask_reg <= 2'b00;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      status_reg <= 2'b00;
    end else begin
      status_reg <= status_next;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // read data
  always @* begin
    hit        = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr)
      `OFS_CONTROL: begin
        rdata_next[`CTL_MODE_LSB+2:`CTL_MODE_LSB] = mode;
        rdata_next[`CTL_OUT_INVERT]  = control_reg[`CTL_OUT_INVERT];
        rdata_next[`CTL_OUT_LEVEL]   = cell_out;
        rdata_next[`CTL_RISE_IRQ_EN] = control_reg[`CTL_RISE_IRQ_EN];
        rdata_next[`CTL_FALL_IRQ_EN] = control_reg[`CTL_FALL_IRQ_EN];
      end
      `OFS_SELECT: begin
        rdata_next[14:0] = select_reg;
      end
      `OFS_IRQ_STATUS: begin
        rdata_next[1:0] = status_reg;
      end
      `OFS_IRQ_MASK: begin
        rdata_next[1:0] = mask_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // one-cycle pready for each taken access, error only for an unmapped address, read data only for reads
  always @(posedge clock) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit;
      if (rd) begin
        prdata <= rdata_next;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/cell_chk_asserts.sv */
// Purpose: port checks for logic_cell
// Assumes: bound to each instance
// Notes: copies control bits 5:0
`timescale 1ns/1ps
`default_nettype none
module cell_chk (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cell_out,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [5:0] ctl_reg;
  wire logic  rd0 = pready && !pwrite && paddr == 12'h000;
  wire logic  wr0 = pready && pwrite && paddr == 12'h000;
  always_ff @(posedge clock) ctl_reg <= reset ? 6'h00 : wr0 ? pwdata[5:0] : ctl_reg;
  a_ready_due: assert property (psel && penable && !pready |=> pready) else $error("late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_level_read: assert property (
    rd0 && $stable(cell_out) |-> prdata[6] == cell_out) else $error("bad level");
  a_ctl_unused: assert property (
    rd0 |-> prdata[31:10] == 22'h0 && prdata[4:3] == 2'h0) else $error("ctl bits");
  a_sel_unused: assert property (
    pready && paddr == 12'h004 |-> (prdata & 32'hffff8888) == 32'h0) else $error("sel bits");
  a_bad_addr: assert property (
    pready && paddr > 12'h00c |-> pslverr && prdata == 32'h0) else $error("no error");
  a_good_addr: assert property (
    pready && paddr[1:0] == 2'h0 && paddr < 12'h010 |-> !pslverr) else $error("false error");
  a_invert_flip: assert property (
    wr0 && !ctl_reg[2] && pwdata[2:0] == ctl_reg[2:0] && pwdata[5] != ctl_reg[5]
    |-> ##[1:3] $changed(cell_out)) else $error("no flip");
endmodule
bind logic_cell cell_chk cell_chk_i (.*);
`default_nettype wire

/* File: test/source_model.sv */
// Purpose: far-side sources for the selectors
// Assumes: code names the source showing level
// Notes: all other sources show the inverse level
`timescale 1ns/1ps
`default_nettype none
module source_model (
  input  wire logic       clock,
  input  wire logic [2:0] code,
  input  wire logic       level,
  output var  logic [7:0] src
);
  always_ff @(posedge clock) src <= {8{~level}} ^ (8'h01 << code);
endmodule
`default_nettype wire

/* File: test/logic_cell_bench.sv */
// Purpose: self-checking bench for one logic cell
// Assumes: cell index 0
// Notes: table rows hold select, mode, code, expected output; level is always 1
`timescale 1ns/1ps
`default_nettype none
module logic_cell_bench;
  logic        clock = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        lv = 1'h1, pready, pslverr, cell_out, irq;
  logic [2:0]  code = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0]  src;
  int          mismatches = 0, num_checks = 0;
  logic [31:0] tab [21] = '{32'h32100301, 32'h32100320, 32'h32100411, 32'h32100400,
    32'h32100431, 32'h32100420, 32'h12100511, 32'h12100500, 32'h32100611, 32'h32100630,
    32'h32000701, 32'h32000711, 32'h32000720, 32'h00000201, 32'h11110211, 32'h22220221,
    32'h33330231, 32'h44440241, 32'h55550251, 32'h66660261, 32'h77770271};
  initial forever #10 clock = ~clock;
  source_model source_model_i (.clock, .code, .level(lv), .src);
  logic_cell logic_cell_i (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src_1(src), .src_2(src), .src_3(src),
    .cell_pin_b_input(src[0]), .sibling_cell_out(src[1]), .capture_output(src[2]),
    .serial_data_in(src[3]), .comparator_three(src[4]), .clock_calendar_event(src[5]),
    .compare_match_event_a(src[6]), .compare_match_event_b(src[7]), .cell_out, .irq);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) begin
      mismatches++;
      end_sim();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic drive(input logic [2:0] c, input logic l);
    @(posedge clock);
    code <= c;
    lv <= l;
    repeat (6) @(posedge clock);
  endtask
  task automatic t_regs;
    apb(1'h1, 12'h004, 32'hffffffff);
    apb(1'h0, 12'h004, 32'h0);
    chk("sel bits", prdata, 32'h00007777);
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped", pslverr, 32'h1);
    $display("registers done");
  endtask
  task automatic t_comb;
    logic [3:0] x;
    logic       e;
    apb(1'h1, 12'h004, 32'h00003210);
    for (int m = 0; m < 6; m++) begin
      apb(1'h1, 12'h000, 32'(m / 2 + 32 * (m % 2)));
      for (int i = 0; i < 16; i++) begin
        drive(i[2:0], i[3]);
        x = i[3] ? 4'h1 << i[2:0] : ~(4'h1 << i[2:0]);
        e = m < 2 ? x[0] & x[1] | x[2] & x[3] : m < 4 ? (x[0] | x[1]) ^ (x[2] | x[3]) : &x;
        chk("comb out", cell_out, e ^ m[0]);
      end
    end
    $display("combinational done");
  endtask
  task automatic t_tab;
    foreach (tab[j]) begin
      apb(1'h1, 12'h004, {16'h0, tab[j][31:16]});
      apb(1'h1, 12'h000, {29'h0, tab[j][10:8]});
      drive(tab[j][6:4], 1'h1);
      chk("table out", cell_out, tab[j][0]);
    end
    $display("table done");
  endtask
  task automatic t_irq;
    apb(1'h1, 12'h00c, 32'h0);
    apb(1'h1, 12'h000, 32'h00000102);
    drive(3'h0, 1'h1);
    drive(3'h7, 1'h1);
    chk("masked irq", irq, 32'h0);
    apb(1'h1, 12'h00c, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq", irq, 32'h1);
    apb(1'h0, 12'h008, 32'h0);
    chk("status", prdata, 32'h1);
    repeat (2) @(posedge clock);
    chk("cleared irq", irq, 32'h0);
    apb(1'h0, 12'h000, 32'h0);
    chk("control", prdata, 32'h00000142);
    apb(1'h1, 12'h000, 32'h00000202);
    apb(1'h1, 12'h00c, 32'h2);
    drive(3'h0, 1'h1);
    chk("fall irq", irq, 32'h1);
    apb(1'h0, 12'h008, 32'h0);
    chk("fall status", prdata, 32'h2);
    $display("interrupts done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    t_regs();
    t_comb();
    t_tab();
    t_irq();
    end_sim();
  end
endmodule
`default_nettype wire
